/* File: verilog/hub_host_control_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_host_control_registers
    import hub_regs_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,

    // Host register port, decoded from the serial link.
    input  wire logic        host_wr_en,
    input  wire logic        host_rd_en,
    input  wire logic [7:0]  host_addr,
    input  wire logic [7:0]  host_wr_data,
    output logic      [7:0]  host_rd_data,

    // Control settings seen by the core.
    output logic             host_asleep,
    output logic             north_east_down_axes,
    output logic             self_test_request,
    output logic             algo_pause_request,
    output logic             sensors_power_down,
    output logic             sensors_restart,
    output logic             discard_pending,

    // FIFO status from the core.
    input  wire logic        wake_fifo_irq_cond,
    input  wire logic        nonwake_fifo_irq_cond,
    input  wire logic        wake_sensor_event,
    input  wire logic        fifo_data_left,
    input  wire logic [15:0] fifo_level,
    input  wire logic        count_publish,
    input  wire logic        transfer_active,
    input  wire logic        algo_paused,

    // Host interrupt and published count.
    output logic             host_irq,
    output logic      [15:0] bytes_available,
    output logic             new_transfer_request,

    // Parameter mailbox.
    output logic             param_req_pulse,
    output logic             param_req_write,
    output logic      [6:0]  param_req_number,
    output logic      [63:0] param_payload,
    output logic      [7:0]  param_ack,
    input  wire logic        param_done,
    input  wire logic        param_unsupported,

    // Scratch areas seen by the core.
    output logic      [47:0] scratch_a,
    output logic      [55:0] scratch_b,

    // Version sources.
    input  wire logic        fixed_code_present,
    input  wire logic [15:0] fixed_code_ver_in,
    input  wire logic        patch_present,
    input  wire logic [15:0] patch_ver_in
);

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PAUSING,
        ST_STANDBY
    } power_state_t;

    typedef struct packed {
        logic [7:0]   ctl;
        logic [7:0]   cmd;
        logic [7:0]   ack;
        logic [15:0]  count;
        logic [15:0]  committed;
        logic         irq;
        logic         refresh_seen;
        logic         cancel_seen;
        logic         cancel_pending;
        logic         restart;
        logic         req_pulse;
        logic [7:0]   rd_data;
        power_state_t pstate;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;

    logic       a_hit;
    logic [7:0] a_data;
    logic       p_hit;
    logic [7:0] p_data;
    logic       b_hit;
    logic [7:0] b_data;

    logic [15:0] fixed_ver;
    logic [15:0] patch_ver;

    logic        wake_ok;
    logic        nonwake_ok;
    logic        irq_raise;
    logic        irq_drop;
    logic        refresh_rise;
    logic        cancel_rise;

    // Rising edge of a level-held command bit against its delayed copy.
    function automatic logic edge_up(input logic now, input logic seen);
        edge_up = now && !seen;
    endfunction : edge_up

    // Version registers report zero when nothing is loaded.
    assign fixed_ver = fixed_code_present ? fixed_code_ver_in : VERSION_ABSENT;
    assign patch_ver = patch_present ? patch_ver_in : VERSION_ABSENT;

    // Scratch and mailbox buffers.
    byte_bank #(
        .BYTES(SCRATCH_A_BYTES),
        .BASE (ADDR_SCRATCH_A_FIRST)
    ) u_scratch_a (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (host_wr_en),
        .wr_addr  (host_addr),
        .wr_data  (host_wr_data),
        .rd_addr  (host_addr),
        .rd_hit   (a_hit),
        .rd_data  (a_data),
        .core_view(scratch_a)
    );

    byte_bank #(
        .BYTES(PARAM_BUF_BYTES),
        .BASE (ADDR_PARAM_BUF_FIRST)
    ) u_param_buf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (host_wr_en),
        .wr_addr  (host_addr),
        .wr_data  (host_wr_data),
        .rd_addr  (host_addr),
        .rd_hit   (p_hit),
        .rd_data  (p_data),
        .core_view(param_payload)
    );

    byte_bank #(
        .BYTES(SCRATCH_B_BYTES),
        .BASE (ADDR_SCRATCH_B_FIRST)
    ) u_scratch_b (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (host_wr_en),
        .wr_addr  (host_addr),
        .wr_data  (host_wr_data),
        .rd_addr  (host_addr),
        .rd_hit   (b_hit),
        .rd_data  (b_data),
        .core_view(scratch_b)
    );

    // Interrupt qualification per FIFO.
    assign wake_ok    = wake_fifo_irq_cond && !s_reg.ctl[CTL_WAKE_INT_DISABLE];
    assign nonwake_ok = nonwake_fifo_irq_cond && !s_reg.ctl[CTL_NONWAKE_INT_DISABLE]
                        && !s_reg.ctl[CTL_HOST_ASLEEP];

    // A standing interrupt drops once neither FIFO qualifies, or on a count publish outside a transfer.
    assign irq_raise = !s_reg.irq && (wake_ok || nonwake_ok) && !s_reg.cancel_pending;
    assign irq_drop  = s_reg.irq && ((!transfer_active && count_publish)
                                     || (!wake_ok && !nonwake_ok));

    // Command bits act once per rising edge.
    assign refresh_rise = edge_up(s_reg.ctl[CTL_REFRESH_COUNT], s_reg.refresh_seen);
    assign cancel_rise  = edge_up(s_reg.ctl[CTL_READOUT_CANCEL], s_reg.cancel_seen);

    always_comb begin
        s_next           = s_reg;
        s_next.req_pulse = 1'b0;
        s_next.restart   = 1'b0;

        // Host writes of the control and command registers.
        if (host_wr_en) begin
            if (host_addr == ADDR_HOST_LINK_CONTROL) begin
                s_next.ctl = host_wr_data;
            end else if (host_addr == ADDR_PARAM_IO_COMMAND) begin
                s_next.cmd       = host_wr_data;
                s_next.ack       = PARAM_ACK_CLEAR;
                s_next.req_pulse = 1'b1;
            end
        end

        // Mailbox completion; a new request in the same cycle wins.
        if (param_done && !s_next.req_pulse) begin
            s_next.ack = param_unsupported ? PARAM_ACK_ERROR : s_reg.cmd;
        end

        // Rising edges of the level-held command bits.
        s_next.refresh_seen = s_reg.ctl[CTL_REFRESH_COUNT];
        s_next.cancel_seen  = s_reg.ctl[CTL_READOUT_CANCEL];

        // Interrupt drive; count published in the same cycle as assertion.
        if (irq_raise) begin
            s_next.irq       = 1'b1;
            s_next.count     = fifo_level;
            s_next.committed = fifo_level;
        end else if (irq_drop) begin
            s_next.irq = 1'b0;
        end

        // During an active transfer, refresh never grows past the count already committed.
        if (refresh_rise) begin
            if (transfer_active && fifo_level > s_reg.committed) begin
                s_next.count = s_reg.committed;
            end else begin
                s_next.count = fifo_level;
            end
        end

        // Cancel drops the interrupt, zeroes the count, discards data.
        // The pending flag also holds the interrupt down for one cycle.
        if (cancel_rise) begin
            s_next.irq            = 1'b0;
            s_next.count          = COUNT_ZERO;
            s_next.committed      = COUNT_ZERO;
            s_next.cancel_pending = 1'b1;
        end else if (s_reg.cancel_pending) begin
            s_next.cancel_pending = 1'b0;
        end

        // Standby sequencing.
        case (s_reg.pstate)
            ST_RUN: begin
                if (s_reg.ctl[CTL_ALGO_STANDBY]) begin
                    s_next.pstate = ST_PAUSING;
                end
            end
            ST_PAUSING: begin
                if (!s_reg.ctl[CTL_ALGO_STANDBY]) begin
                    s_next.pstate = ST_RUN;
                end else if (algo_paused) begin
                    s_next.pstate = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (!s_reg.ctl[CTL_ALGO_STANDBY]) begin
                    s_next.pstate  = ST_RUN;
                    s_next.restart = 1'b1;
                end
            end
            default: begin
                s_next.pstate = ST_RUN;
            end
        endcase

        // Registered read data.
        s_next.rd_data = BYTE_ZERO;
        if (host_rd_en) begin
            if (host_addr == ADDR_HOST_LINK_CONTROL) begin
                s_next.rd_data = s_reg.ctl;
            end else if (host_addr == ADDR_PARAM_IO_COMMAND) begin
                s_next.rd_data = s_reg.cmd;
            end else if (host_addr == ADDR_FIXED_VER_LO) begin
                s_next.rd_data = fixed_ver[7:0];
            end else if (host_addr == ADDR_FIXED_VER_HI) begin
                s_next.rd_data = fixed_ver[15:8];
            end else if (host_addr == ADDR_PATCH_VER_LO) begin
                s_next.rd_data = patch_ver[7:0];
            end else if (host_addr == ADDR_PATCH_VER_HI) begin
                s_next.rd_data = patch_ver[15:8];
            end else if (a_hit) begin
                s_next.rd_data = a_data;
            end else if (p_hit) begin
                s_next.rd_data = p_data;
            end else if (b_hit) begin
                s_next.rd_data = b_data;
            end
        end
    end

    // Edge trackers clear with the control byte, so no false edge follows reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg.ctl            <= CTL_RESET;
            s_reg.cmd            <= BYTE_ZERO;
            s_reg.ack            <= PARAM_ACK_CLEAR;
            s_reg.count          <= COUNT_ZERO;
            s_reg.committed      <= COUNT_ZERO;
            s_reg.irq            <= 1'b0;
            s_reg.refresh_seen   <= 1'b0;
            s_reg.cancel_seen    <= 1'b0;
            s_reg.cancel_pending <= 1'b0;
            s_reg.restart        <= 1'b0;
            s_reg.req_pulse      <= 1'b0;
            s_reg.rd_data        <= BYTE_ZERO;
            s_reg.pstate         <= ST_RUN;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs to the core and host.
    assign host_rd_data         = s_reg.rd_data;
    assign host_asleep          = s_reg.ctl[CTL_HOST_ASLEEP];
    assign north_east_down_axes = s_reg.ctl[CTL_NORTH_EAST_DOWN];
    assign self_test_request    = s_reg.restart && s_reg.ctl[CTL_SELF_TEST_ON_WAKE];
    assign algo_pause_request   = s_reg.pstate != ST_RUN;
    assign sensors_power_down   = s_reg.pstate == ST_STANDBY;
    assign sensors_restart      = s_reg.restart;
    assign discard_pending      = s_reg.cancel_pending;
    assign new_transfer_request = s_reg.cancel_pending && fifo_data_left;
    assign host_irq             = s_reg.irq;
    assign bytes_available      = s_reg.count;

    // Mailbox outputs.
    assign param_req_pulse      = s_reg.req_pulse;
    assign param_req_write      = s_reg.cmd[PARAM_DIR_BIT] == PARAM_DIR_WRITE;
    assign param_req_number     = s_reg.cmd[PARAM_DIR_BIT-1:0];
    assign param_ack            = s_reg.ack;

endmodule : hub_host_control_registers
`default_nettype wire

/* File: verilog/hub_regs_pkg.sv */
package hub_regs_pkg;

    // Byte addresses of the host-visible registers.
    localparam logic [7:0] ADDR_HOST_LINK_CONTROL = 8'h55;
    localparam logic [7:0] ADDR_SCRATCH_A_FIRST   = 8'h56;
    localparam logic [7:0] ADDR_SCRATCH_A_LAST    = 8'h5B;
    localparam logic [7:0] ADDR_PARAM_BUF_FIRST   = 8'h5C;
    localparam logic [7:0] ADDR_PARAM_BUF_LAST    = 8'h63;
    localparam logic [7:0] ADDR_PARAM_IO_COMMAND  = 8'h64;
    localparam logic [7:0] ADDR_SCRATCH_B_FIRST   = 8'h65;
    localparam logic [7:0] ADDR_SCRATCH_B_LAST    = 8'h6B;
    localparam logic [7:0] ADDR_FIXED_VER_LO      = 8'h70;
    localparam logic [7:0] ADDR_FIXED_VER_HI      = 8'h71;
    localparam logic [7:0] ADDR_PATCH_VER_LO      = 8'h72;
    localparam logic [7:0] ADDR_PATCH_VER_HI      = 8'h73;

    // Array sizes.
    localparam int SCRATCH_A_BYTES = 6;
    localparam int PARAM_BUF_BYTES = 8;
    localparam int SCRATCH_B_BYTES = 7;

    // Control register bit positions.
    localparam int CTL_NONWAKE_INT_DISABLE = 7;
    localparam int CTL_SELF_TEST_ON_WAKE   = 6;
    localparam int CTL_HOST_ASLEEP         = 5;
    localparam int CTL_NORTH_EAST_DOWN     = 4;
    localparam int CTL_WAKE_INT_DISABLE    = 3;
    localparam int CTL_REFRESH_COUNT       = 2;
    localparam int CTL_READOUT_CANCEL      = 1;
    localparam int CTL_ALGO_STANDBY        = 0;

    // Parameter command fields.
    localparam int PARAM_DIR_BIT = 7;
    localparam logic PARAM_DIR_READ  = 1'b0;
    localparam logic PARAM_DIR_WRITE = 1'b1;

    // Reset and special values.
    localparam logic [7:0]  CTL_RESET        = 8'h00;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    localparam logic [15:0] COUNT_ZERO       = 16'h0000;
    localparam logic [15:0] VERSION_ABSENT   = 16'h0000;
    localparam logic [7:0]  PARAM_ACK_CLEAR  = 8'h00;
    localparam logic [7:0]  PARAM_ACK_ERROR  = 8'h80;

endpackage : hub_regs_pkg

/* File: verilog/byte_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_bank
    import hub_regs_pkg::*;
#(
    parameter int         BYTES = 8,
    parameter logic [7:0] BASE  = 8'h00
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Host write.
    input  wire logic               wr_en,
    input  wire logic [7:0]         wr_addr,
    input  wire logic [7:0]         wr_data,
    // Read port.
    input  wire logic [7:0]         rd_addr,
    output logic                    rd_hit,
    output logic      [7:0]         rd_data,
    // Core view.
    output logic      [BYTES*8-1:0] core_view
);

    typedef struct packed {
        logic [BYTES-1:0][7:0] mem;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;

    // Whether an address is inside the bank.
    function automatic logic in_bank(input logic [7:0] a);
        in_bank = (a >= BASE) && (a < BASE + 8'(BYTES));
    endfunction : in_bank

    always_comb begin
        state_next = state_reg;
        if (wr_en && in_bank(wr_addr)) begin
            state_next.mem[3'(wr_addr - BASE)] = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_hit    = in_bank(rd_addr);
    assign rd_data   = rd_hit ? state_reg.mem[3'(rd_addr - BASE)] : BYTE_ZERO;
    assign core_view = state_reg.mem;

endmodule : byte_bank
`default_nettype wire

/* File: verif/hub_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_regs_monitor
    import hub_regs_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Host port.
    input  wire logic        host_wr_en,
    input  wire logic        host_rd_en,
    input  wire logic [7:0]  host_addr,
    input  wire logic [7:0]  host_wr_data,
    input  wire logic [7:0]  host_rd_data,
    // Core side.
    input  wire logic        host_asleep,
    input  wire logic        north_east_down_axes,
    input  wire logic        discard_pending,
    input  wire logic        fifo_data_left,
    input  wire logic        host_irq,
    input  wire logic [15:0] bytes_available,
    input  wire logic        new_transfer_request,
    input  wire logic        param_req_pulse,
    input  wire logic        param_req_write,
    input  wire logic [6:0]  param_req_number,
    input  wire logic [7:0]  param_ack,
    input  wire logic        param_done,
    input  wire logic        param_unsupported,
    input  wire logic [47:0] scratch_a,
    input  wire logic        fixed_code_present,
    input  wire logic [15:0] fixed_code_ver_in
);
    logic [7:0] ctl_reg;
    logic [7:0] ver_lo;
    logic [7:0] cmd_now;
    logic       ctl_wr;
    logic       cmd_wr;
    assign ctl_wr  = host_wr_en && host_addr == ADDR_HOST_LINK_CONTROL;
    assign cmd_wr  = host_wr_en && host_addr == ADDR_PARAM_IO_COMMAND;
    assign ver_lo  = fixed_code_present ? fixed_code_ver_in[7:0] : 8'h00;
    assign cmd_now = {param_req_write, param_req_number};
    // Shadow of the control byte as the host wrote it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_reg <= 8'h00;
        end else if (ctl_wr) begin
            ctl_reg <= host_wr_data;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_ctl_mirror: assert property (
        host_asleep == ctl_reg[5] && north_east_down_axes == ctl_reg[4])
        else $error("control outputs differ from control byte");
    chk_rd_fixed: assert property (
        host_rd_en && host_addr == ADDR_FIXED_VER_LO |=> host_rd_data == $past(ver_lo))
        else $error("fixed version low byte read wrong");
    chk_req_issue: assert property (
        cmd_wr |-> ##[1:2] (param_req_pulse && param_ack == PARAM_ACK_CLEAR))
        else $error("request did not clear acknowledge");
    chk_req_decode: assert property (
        cmd_wr |=> cmd_now == $past(host_wr_data))
        else $error("request fields wrong");
    chk_ack_good: assert property (
        param_done && !param_unsupported && !cmd_wr && !param_req_pulse
        |=> param_ack == $past(cmd_now))
        else $error("acknowledge does not match request");
    chk_ack_error: assert property (
        param_done && param_unsupported && !cmd_wr && !param_req_pulse
        |=> param_ack == PARAM_ACK_ERROR)
        else $error("unsupported request not flagged");
    chk_cancel_kick: assert property (
        ctl_wr && host_wr_data[1] && !ctl_reg[1] |-> ##[1:3] discard_pending)
        else $error("cancel did not discard");
    chk_cancel_clear: assert property (
        discard_pending |-> !host_irq && bytes_available == COUNT_ZERO ##1 !discard_pending)
        else $error("cancel left interrupt or count");
    chk_new_xfer: assert property (
        new_transfer_request == (discard_pending && fifo_data_left))
        else $error("new transfer request wrong");
    chk_irq_block: assert property (
        ctl_reg[3] && ctl_reg[7] && $past(ctl_reg[3]) && $past(ctl_reg[7]) |-> !host_irq)
        else $error("interrupt while disabled");
    chk_scratch_wr: assert property (
        host_wr_en && host_addr == ADDR_SCRATCH_A_FIRST |=> scratch_a[7:0] == $past(host_wr_data))
        else $error("scratch byte not taken");
endmodule : hub_regs_monitor
bind hub_host_control_registers hub_regs_monitor u_monitor (
    .clk, .sys_rst, .host_wr_en, .host_rd_en, .host_addr, .host_wr_data, .host_rd_data,
    .host_asleep, .north_east_down_axes, .discard_pending, .fifo_data_left, .host_irq,
    .bytes_available, .new_transfer_request, .param_req_pulse, .param_req_write,
    .param_req_number, .param_ack, .param_done, .param_unsupported, .scratch_a,
    .fixed_code_present, .fixed_code_ver_in
);
`default_nettype wire

/* File: verif/core_param_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_param_model
    import hub_regs_pkg::*;
#(
    parameter logic [6:0] UNSUP_FROM = 7'h40
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Request from the registers.
    input  wire logic       slow,
    input  wire logic       param_req_pulse,
    input  wire logic [6:0] param_req_number,
    // Completion.
    output logic            param_done,
    output logic            param_unsupported
);
    logic [3:0] wait_reg;
    logic       busy_reg;
    logic       bad_reg;
    logic       junk_reg;
    // The error flag toggles while no completion qualifies it.
    assign param_unsupported = param_done ? bad_reg : junk_reg;
    always_ff @(posedge clk) begin
        junk_reg   <= ~junk_reg;
        param_done <= 1'b0;
        if (sys_rst) begin
            busy_reg <= 1'b0;
            junk_reg <= 1'b0;
        end else if (param_req_pulse) begin
            busy_reg <= 1'b1;
            wait_reg <= slow ? 4'h9 : 4'h0;
            bad_reg  <= param_req_number >= UNSUP_FROM;
        end else if (busy_reg && wait_reg == 4'h0) begin
            busy_reg   <= 1'b0;
            param_done <= 1'b1;
        end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule : core_param_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hub_regs_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    typedef struct packed {logic [7:0] c; logic w; logic n; logic e;} irq_t;
    logic clk, sys_rst, host_wr_en, host_rd_en, slow, host_asleep, north_east_down_axes;
    logic wake_fifo_irq_cond, nonwake_fifo_irq_cond, wake_sensor_event, fifo_data_left;
    logic count_publish, transfer_active, algo_paused, fixed_code_present, patch_present;
    logic self_test_request, algo_pause_request, sensors_power_down, sensors_restart;
    logic discard_pending, host_irq, new_transfer_request, param_req_pulse, param_req_write;
    logic param_done, param_unsupported;
    logic [7:0]  host_addr, host_wr_data, host_rd_data, param_ack, rdat;
    logic [6:0]  param_req_number;
    logic [15:0] fifo_level, bytes_available, fixed_code_ver_in, patch_ver_in;
    logic [47:0] scratch_a;
    logic [55:0] scratch_b;
    logic [63:0] param_payload;
    int          fails, total_checks, n;
    row_t rows [9] = '{'{8'h55, 8'h30, 8'h30}, '{8'h56, 8'hA5, 8'hA5}, '{8'h5B, 8'h5A, 8'h5A},
        '{8'h65, 8'h3C, 8'h3C}, '{8'h6B, 8'hC3, 8'hC3}, '{8'h70, 8'hFF, 8'h57},
        '{8'h71, 8'hFF, 8'h13}, '{8'h72, 8'hFF, 8'h00}, '{8'h80, 8'hFF, 8'h00}};
    irq_t irqs [7] = '{'{8'h00, 1, 0, 1}, '{8'h08, 1, 0, 0}, '{8'h00, 0, 1, 1},
        '{8'h80, 0, 1, 0}, '{8'h20, 0, 1, 0}, '{8'h20, 1, 0, 1}, '{8'h88, 1, 1, 0}};
    logic [7:0] cmds [3] = '{8'h85, 8'h03, 8'hC5};
    logic [7:0] acks [3] = '{8'h85, 8'h03, 8'h80};
    hub_host_control_registers u_dut (.clk, .sys_rst, .host_wr_en, .host_rd_en, .host_addr,
        .host_wr_data, .host_rd_data, .host_asleep, .north_east_down_axes, .self_test_request,
        .algo_pause_request, .sensors_power_down, .sensors_restart, .discard_pending,
        .wake_fifo_irq_cond, .nonwake_fifo_irq_cond, .wake_sensor_event, .fifo_data_left,
        .fifo_level, .count_publish, .transfer_active, .algo_paused, .host_irq,
        .bytes_available, .new_transfer_request, .param_req_pulse, .param_req_write,
        .param_req_number, .param_payload, .param_ack, .param_done, .param_unsupported,
        .scratch_a, .scratch_b, .fixed_code_present, .fixed_code_ver_in, .patch_present,
        .patch_ver_in);
    core_param_model u_core (.clk, .sys_rst, .slow, .param_req_pulse, .param_req_number,
        .param_done, .param_unsupported);
    always #2 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        host_wr_en = 1'b1;
        host_addr = a;
        host_wr_data = d;
        tick(1);
        host_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        tick(1);
        host_rd_en = 1'b1;
        host_addr = a;
        tick(1);
        host_rd_en = 1'b0;
        rdat = host_rd_data;
    endtask : rd
    task automatic bound(input int lim);
        if (n >= lim) begin
            fails++;
            test_done();
        end
    endtask : bound
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        {clk, host_wr_en, host_rd_en, slow, wake_fifo_irq_cond, nonwake_fifo_irq_cond} = 0;
        {wake_sensor_event, fifo_data_left, count_publish, transfer_active, algo_paused} = 0;
        {host_addr, host_wr_data, fifo_level, patch_present, fails, total_checks} = 0;
        fixed_code_present = 1'b1;
        fixed_code_ver_in = 16'h1357;
        patch_ver_in = 16'h2468;
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check("readback", rdat, rows[i].e);
        end
        check("axes", {host_asleep, north_east_down_axes}, 2'b11);
        check("scratch", {scratch_a[47:40], scratch_a[7:0], scratch_b[55:48], scratch_b[7:0]},
            32'h5AA5C33C);
        fixed_code_present = 1'b0;
        patch_present = 1'b1;
        rd(ADDR_FIXED_VER_LO);
        check("fixed absent", rdat, 8'h00);
        rd(ADDR_PATCH_VER_HI);
        check("patch hi", rdat, 8'h24);
        for (int i = 0; i < 8; i++) wr(ADDR_PARAM_BUF_FIRST + i, 8'h10 + i);
        check("payload", param_payload, 64'h1716151413121110);
        for (int i = 0; i < 3; i++) begin
            slow = i[0];
            wr(ADDR_PARAM_IO_COMMAND, cmds[i]);
            tick(1);
            check("ack cleared", param_ack, 8'h00);
            check("command", {param_req_write, param_req_number}, cmds[i]);
            for (n = 0; n < 30 && param_ack !== acks[i]; n++) tick(1);
            bound(30);
            check("ack", param_ack, acks[i]);
        end
        fifo_level = 16'h0040;
        foreach (irqs[i]) begin
            wr(ADDR_HOST_LINK_CONTROL, irqs[i].c);
            {wake_fifo_irq_cond, nonwake_fifo_irq_cond} = {irqs[i].w, irqs[i].n};
            tick(4);
            check("irq", host_irq, irqs[i].e);
            if (irqs[i].e) check("count", bytes_available, 16'h0040);
            {wake_fifo_irq_cond, nonwake_fifo_irq_cond, count_publish} = 3'b001;
            tick(2);
            count_publish = 1'b0;
        end
        wr(ADDR_HOST_LINK_CONTROL, 8'h00);
        wake_fifo_irq_cond = 1'b1;
        transfer_active = 1'b1;
        tick(4);
        fifo_level = 16'h0070;
        wr(ADDR_HOST_LINK_CONTROL, 8'h04);
        tick(3);
        check("capped", bytes_available, 16'h0040);
        transfer_active = 1'b0;
        fifo_level = 16'h0030;
        wr(ADDR_HOST_LINK_CONTROL, 8'h00);
        tick(3);
        wr(ADDR_HOST_LINK_CONTROL, 8'h04);
        tick(3);
        check("refresh", bytes_available, 16'h0030);
        rd(ADDR_HOST_LINK_CONTROL);
        check("no self clear", rdat, 8'h04);
        wr(ADDR_HOST_LINK_CONTROL, 8'h08);
        tick(1);
        check("wake off", host_irq, 1'b0);
        wr(ADDR_HOST_LINK_CONTROL, 8'h00);
        tick(4);
        fifo_data_left = 1'b1;
        check("irq before cancel", host_irq, 1'b1);
        wr(ADDR_HOST_LINK_CONTROL, 8'h02);
        for (n = 0; n < 6 && discard_pending !== 1'b1; n++) tick(1);
        bound(6);
        check("cancel", {host_irq, bytes_available, new_transfer_request}, 18'h1);
        wake_fifo_irq_cond = 1'b0;
        wr(ADDR_HOST_LINK_CONTROL, 8'h41);
        tick(2);
        check("pausing", {algo_pause_request, sensors_power_down}, 2'b10);
        algo_paused = 1'b1;
        tick(3);
        check("standby", sensors_power_down, 1'b1);
        wr(ADDR_HOST_LINK_CONTROL, 8'h40);
        for (n = 0; n < 6 && sensors_restart !== 1'b1; n++) tick(1);
        bound(6);
        check("self test", self_test_request, 1'b1);
        algo_paused = 1'b0;
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        rd(ADDR_HOST_LINK_CONTROL);
        check("reset ctl", {rdat, host_irq, bytes_available, sensors_power_down}, 26'h0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
